// >>> logic/tbw_pkg.sv
package tbw_pkg;

  // clock and derived timing
  localparam int unsigned CLK_NS   = 5;                  // 200 MHz system clock
  localparam int unsigned FILT_NS  = 3_000_000;          // 3.0 ms digital input filter
  localparam int unsigned FILT_CYC = FILT_NS / CLK_NS;   // filter length in cycles
  localparam int unsigned TICK_NS  = 1_000_000;          // timer resolution, 1 ms
  localparam int unsigned TICK_CYC = TICK_NS / CLK_NS;   // cycles per millisecond tick

  // register byte addresses on apb
  localparam logic [7:0] ADDR_OUT_IMG = 8'h00;  // data0, data1, control byte from controller
  localparam logic [7:0] ADDR_IN_IMG  = 8'h04;  // data0, data1, status byte to controller
  localparam logic [7:0] ADDR_PERIOD  = 8'h08;  // cycle monitoring period, ms
  localparam logic [7:0] ADDR_MIN_OFF = 8'h0c;  // min_off_time_setting, ms

  // field positions and reset values
  localparam int unsigned TOGGLE_BIT  = 0;           // watched bit inside output data byte 0
  localparam int unsigned IMG_W       = 24;          // two data bytes plus one control/status
  localparam int unsigned DIN_N       = 2;           // digital inputs, input 0 is the enable
  localparam int unsigned RELAY_N     = 2;           // make contacts
  localparam logic [15:0] PERIOD_RST  = 16'h0064;    // 100 ms
  localparam logic [15:0] MIN_OFF_RST = 16'h03e8;    // 1000 ms
  localparam logic [23:0] OUT_IMG_RST = 24'h000000;

  // watchdog states, one-hot
  typedef enum logic [3:0] {
    ST_IDLE  = 4'h1,   // relays open, waiting for an enable falling edge
    ST_ARMED = 4'h2,   // armed, waiting for one full toggle cycle
    ST_RUN   = 4'h4,   // relays closed, toggling good
    ST_TRIP  = 4'h8    // tripped, relays held open for the minimum off time
  } tbw_state_t;

endpackage : tbw_pkg

// >>> logic/tbw_in_if.sv
interface tbw_in_if;
  logic pin;    // raw field input, asynchronous
  logic level;  // synchronised, filtered level
  logic fall;   // one-cycle pulse on a filtered high-to-low change

  modport filt (input pin, output level, output fall);
  modport core (output pin, input level, input fall);
endinterface : tbw_in_if

// >>> logic/tbw_in_filt.sv
module tbw_in_filt #(
  parameter int unsigned FILT_CYC = tbw_pkg::FILT_CYC
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // filtered input
  tbw_in_if.filt   io
);

  localparam logic [19:0] LIM = 20'(FILT_CYC - 1);

  typedef struct packed {
    logic        s1;
    logic        s2;
    logic        level;
    logic        fall;
    logic [19:0] cnt;
  } tbw_filt_t;

  tbw_filt_t r;
  tbw_filt_t n;

  // a change must stand for the whole filter time before it is accepted
  always_comb begin
    n      = r;
    n.s1   = io.pin;
    n.s2   = r.s1;   // first stage feeds only the second
    n.fall = 1'b0;
    if (r.s2 == r.level) begin
      n.cnt = '0;
    end else if (r.cnt >= LIM) begin
      n.cnt   = '0;
      n.level = r.s2;
      n.fall  = r.level & ~r.s2;
    end else begin
      n.cnt = r.cnt + 20'd1;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      r <= '0;
    end else begin
      r <= n;
    end
  end

  assign io.level = r.level;
  assign io.fall  = r.fall;

endmodule : tbw_in_filt

// >>> logic/tbw_top.sv
// How it works
// - stopped toggle bit opens both relays
// - toggle gap beyond set period is failure
// - only enable falling edge arms monitoring
// - trip holds relays open for minimum time
// - after trip stay open until re-armed
// - close relays after one full toggle cycle
// - one missed cycle trips, stuck low or high
// - three bytes each way per bus cycle
// - relay indicator lit while contact closed
// - watchdog-good indicator lit while toggling good
// - one indicator per input shows its level
module tbw_top #(
  parameter int unsigned FILT_CYC = tbw_pkg::FILT_CYC,
  parameter int unsigned TICK_CYC = tbw_pkg::TICK_CYC
) (
  // clock and reset
  input  wire logic        sys_clk,
  input  wire logic        rst_n,
  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // field inputs, din[0] is the monitoring enable
  input  wire logic [1:0]  din,
  // relay coils
  output logic      [1:0]  relay,
  // indicators
  output logic      [1:0]  led_relay,
  output logic             led_wd_ok,
  output logic      [1:0]  led_din
);

  localparam logic [17:0] TICK_LIM = 18'(TICK_CYC - 1);

  typedef struct packed {
    logic [23:0]         out_img;
    logic [15:0]         period;
    logic [15:0]         min_off;
    tbw_pkg::tbw_state_t st;
    logic [17:0]         tick_cnt;
    logic [15:0]         per_cnt;
    logic [15:0]         off_cnt;
    logic                edges;
    logic [1:0]          relay;
    logic [1:0]          led_relay;
    logic                led_wd_ok;
    logic [1:0]          led_din;
    logic [31:0]         prdata;
    logic                pready;
    logic                pslverr;
  } tbw_core_t;

  tbw_core_t r;
  tbw_core_t n;

  // address decode used by the error path and the unmapped-access check; the read path decodes paddr itself
  function automatic logic addr_ok(input logic [7:0] a);
    addr_ok = (a == tbw_pkg::ADDR_OUT_IMG) || (a == tbw_pkg::ADDR_IN_IMG) ||
              (a == tbw_pkg::ADDR_PERIOD)  || (a == tbw_pkg::ADDR_MIN_OFF);
  endfunction : addr_ok

  // input conditioning, one filter per field input
  logic [1:0] din_level;
  logic [1:0] din_fall;

  for (genvar i = 0; i < tbw_pkg::DIN_N; i++) begin : g_din
    tbw_in_if io ();
    assign io.pin       = din[i];
    assign din_level[i] = io.level;
    assign din_fall[i]  = io.fall;
    tbw_in_filt #(
      .FILT_CYC (FILT_CYC)
    ) u_filt (
      .sys_clk (sys_clk),
      .rst_n   (rst_n),
      .io      (io)
    );
  end

  // bus handshake: every access answers one cycle after penable rises
  logic acc;
  logic done;
  logic wr_out;
  logic tog_edge;
  logic tick;
  logic expire;
  logic fall_en;

  assign acc     = psel & penable;
  assign done    = acc & r.pready;
  assign wr_out  = done & pwrite & (paddr == tbw_pkg::ADDR_OUT_IMG);
  assign fall_en = din_fall[0];
  // the image write is the bus cycle; a flipped bit is a toggle edge
  assign tog_edge = wr_out &&
                    (pwdata[tbw_pkg::TOGGLE_BIT] != r.out_img[tbw_pkg::TOGGLE_BIT]);
  // free running ms tick; resetting it on edges would freeze the off timer
  assign tick   = (r.tick_cnt == TICK_LIM);
  assign expire = tick && (({1'b0, r.per_cnt} + 17'd1) >= {1'b0, r.period});

  always_comb begin
    n = r;

    // millisecond prescaler
    n.tick_cnt = tick ? '0 : r.tick_cnt + 18'd1;

    // period timer, restarted on each toggle edge, saturating
    if (tog_edge) begin
      n.per_cnt = '0;
    end else if (tick && (r.per_cnt != 16'hffff)) begin
      n.per_cnt = r.per_cnt + 16'd1;
    end

    // watchdog sequence
    unique case (r.st)
      tbw_pkg::ST_IDLE: begin
        // a level held high never arms, only the edge does
        if (fall_en) begin
          n.st      = tbw_pkg::ST_ARMED;
          n.edges   = 1'b0;
          n.per_cnt = '0;
        end
      end
      tbw_pkg::ST_ARMED: begin
        if (expire) begin
          n.st      = tbw_pkg::ST_TRIP;
          n.off_cnt = '0;
        end else if (tog_edge) begin
          // two edges make one full cycle: low-high-low or high-low-high
          if (r.edges) begin
            n.st = tbw_pkg::ST_RUN;
          end else begin
            n.edges = 1'b1;
          end
        end
      end
      tbw_pkg::ST_RUN: begin
        // no edge within the period, whichever level the bit sticks at
        if (expire) begin
          n.st      = tbw_pkg::ST_TRIP;
          n.off_cnt = '0;
        end
      end
      tbw_pkg::ST_TRIP: begin
        // good toggling here changes nothing; enable edges are ignored too
        if (r.off_cnt >= r.min_off) begin
          n.st = tbw_pkg::ST_IDLE;
        end else if (tick) begin
          n.off_cnt = r.off_cnt + 16'd1;
        end
      end
      default: begin
        n.st = tbw_pkg::ST_IDLE;
      end
    endcase

    // contacts and relay/good indicators follow the next state so they share its edge; input indicators follow the filtered level
    n.relay     = {2{n.st == tbw_pkg::ST_RUN}};
    n.led_relay = n.relay;
    n.led_wd_ok = (n.st == tbw_pkg::ST_RUN);
    n.led_din   = din_level;

    // apb access phase
    n.pready  = acc & ~r.pready;
    n.pslverr = acc & ~r.pready & ((paddr[1:0] != 2'b00) || !addr_ok(paddr));
    n.prdata  = '0;
    if (acc && !r.pready && !pwrite) begin
      unique case (paddr)
        tbw_pkg::ADDR_OUT_IMG: n.prdata = {8'h00, r.out_img};
        // data0 inputs, data1 contacts and good flag, status the state
        tbw_pkg::ADDR_IN_IMG:  n.prdata = {8'h00, 4'h0, r.st,
                                           5'h00, r.led_wd_ok, r.relay,
                                           6'h00, r.led_din};
        tbw_pkg::ADDR_PERIOD:  n.prdata = {16'h0000, r.period};
        tbw_pkg::ADDR_MIN_OFF: n.prdata = {16'h0000, r.min_off};
        default:               n.prdata = '0;
      endcase
    end

    // writes take effect at the completing edge only
    if (done && pwrite) begin
      unique case (paddr)
        tbw_pkg::ADDR_OUT_IMG: n.out_img = pwdata[23:0];
        tbw_pkg::ADDR_PERIOD:  n.period  = pwdata[15:0];
        tbw_pkg::ADDR_MIN_OFF: n.min_off = pwdata[15:0];
        default: begin
        end
      endcase
    end
  end

  // one state register for the whole block
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      r           <= '0;
      r.out_img   <= tbw_pkg::OUT_IMG_RST;
      r.period    <= tbw_pkg::PERIOD_RST;
      r.min_off   <= tbw_pkg::MIN_OFF_RST;
      r.st        <= tbw_pkg::ST_IDLE;
    end else begin
      r <= n;
    end
  end

  assign prdata    = r.prdata;
  assign pready    = r.pready;
  assign pslverr   = r.pslverr;
  assign relay     = r.relay;
  assign led_relay = r.led_relay;
  assign led_wd_ok = r.led_wd_ok;
  assign led_din   = r.led_din;

  // checks on the watchdog sequence, the indicators and the bus handshake
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!rst_n);

  property p_trip_opens;
    (r.st == tbw_pkg::ST_RUN && expire) |=> (relay == 2'b00) && (r.st == tbw_pkg::ST_TRIP);
  endproperty
  a_trip_opens: assert property (p_trip_opens)
    else $error("missed cycle did not open the relays");

  property p_run_holds;
    (r.st == tbw_pkg::ST_RUN && !expire) |=> (r.st == tbw_pkg::ST_RUN) && (relay == 2'b11);
  endproperty
  a_run_holds: assert property (p_run_holds)
    else $error("relays dropped inside the monitoring period");

  property p_arm_on_fall;
    (r.st == tbw_pkg::ST_IDLE && fall_en) |=> (r.st == tbw_pkg::ST_ARMED) && (relay == 2'b00);
  endproperty
  a_arm_on_fall: assert property (p_arm_on_fall)
    else $error("enable falling edge did not arm");

  property p_no_arm_level;
    (r.st == tbw_pkg::ST_IDLE && !fall_en) |=> (r.st == tbw_pkg::ST_IDLE);
  endproperty
  a_no_arm_level: assert property (p_no_arm_level)
    else $error("left idle without an enable falling edge");

  property p_min_off;
    (r.st == tbw_pkg::ST_TRIP && r.off_cnt < r.min_off) |=>
      (relay == 2'b00) && (r.st == tbw_pkg::ST_TRIP);
  endproperty
  a_min_off: assert property (p_min_off)
    else $error("relays left trip before the minimum off time");

  property p_stay_open;
    (r.st == tbw_pkg::ST_TRIP && tog_edge) ##1 (r.st == tbw_pkg::ST_IDLE && !fall_en) |=>
      (relay == 2'b00);
  endproperty
  a_stay_open: assert property (p_stay_open)
    else $error("relays closed after trip without re-arming");

  property p_close_cycle;
    (r.st == tbw_pkg::ST_ARMED && tog_edge && r.edges && !expire) |=>
      (relay == 2'b11) && (led_relay == 2'b11) && led_wd_ok;
  endproperty
  a_close_cycle: assert property (p_close_cycle)
    else $error("full toggle cycle did not close the relays");

  property p_timer_restart;
    tog_edge |=> (r.per_cnt == 16'h0000);
  endproperty
  a_timer_restart: assert property (p_timer_restart)
    else $error("toggle edge did not restart the period timer");

  property p_din_led;
    ##1 (led_din == $past(din_level));
  endproperty
  a_din_led: assert property (p_din_led)
    else $error("input indicator does not follow the filtered input");

  property p_ready_one;
    pready |=> !pready;
  endproperty
  a_ready_one: assert property (p_ready_one)
    else $error("bus ready stood longer than one cycle");

  property p_ready_answer;
    (psel && penable && !pready) |=> pready;
  endproperty
  a_ready_answer: assert property (p_ready_answer)
    else $error("bus access not answered after one wait state");

  property p_err_unmapped;
    (psel && penable && !pready && !addr_ok(paddr)) |=> pslverr && pready;
  endproperty
  a_err_unmapped: assert property (p_err_unmapped)
    else $error("unmapped access did not report an error");

  property p_rdata_idle;
    !pready |-> (prdata == 32'h00000000);
  endproperty
  a_rdata_idle: assert property (p_rdata_idle)
    else $error("read data shown outside the answer cycle");

  property p_armed_timeout;
    (r.st == tbw_pkg::ST_ARMED && expire) |=> (r.st == tbw_pkg::ST_TRIP) && (relay == 2'b00);
  endproperty
  a_armed_timeout: assert property (p_armed_timeout)
    else $error("armed watchdog did not trip on a late toggle");

  property p_half_cycle;
    (r.st == tbw_pkg::ST_ARMED && tog_edge && !r.edges && !expire) |=>
      (r.st == tbw_pkg::ST_ARMED) && (relay == 2'b00);
  endproperty
  a_half_cycle: assert property (p_half_cycle)
    else $error("relays closed on half a toggle cycle");

  property p_trip_end;
    (r.st == tbw_pkg::ST_TRIP && r.off_cnt >= r.min_off) |=>
      (r.st == tbw_pkg::ST_IDLE) && (relay == 2'b00);
  endproperty
  a_trip_end: assert property (p_trip_end)
    else $error("trip did not fall back to idle with relays open");

  property p_idle_open;
    (r.st == tbw_pkg::ST_IDLE) |-> (relay == 2'b00) && !led_wd_ok;
  endproperty
  a_idle_open: assert property (p_idle_open)
    else $error("relays closed while not armed");

  property p_relay_led;
    led_relay == relay;
  endproperty
  a_relay_led: assert property (p_relay_led)
    else $error("relay indicator differs from the contact");

  property p_wd_led;
    led_wd_ok == (r.st == tbw_pkg::ST_RUN);
  endproperty
  a_wd_led: assert property (p_wd_led)
    else $error("watchdog-good indicator differs from the run state");

  property p_trip_toggle;
    (r.st == tbw_pkg::ST_TRIP && tog_edge && r.off_cnt < r.min_off) |=>
      (r.st == tbw_pkg::ST_TRIP);
  endproperty
  a_trip_toggle: assert property (p_trip_toggle)
    else $error("good toggling cut the trip short");

endmodule : tbw_top

// >>> sim/tbw_ctl_model.sv
module tbw_ctl_model (
  // clock
  input  wire logic        sys_clk,
  // apb master side
  output logic             psel,
  output logic             penable,
  output logic             pwrite,
  output logic      [7:0]  paddr,
  output logic      [31:0] pwdata,
  input  wire logic [31:0] prdata,
  input  wire logic        pready,
  input  wire logic        pslverr
);
  timeunit 1ns;
  timeprecision 1ps;

  logic        tbit;  // watched bit as last sent
  logic [15:0] hi;    // data1 and control bytes sent with every toggle

  // bus idle from time zero
  initial begin
    psel    = 1'b0;
    penable = 1'b0;
    pwrite  = 1'b0;
    paddr   = 8'h00;
    pwdata  = 32'h00000000;
    tbit    = 1'b0;
    hi      = 16'h0000;
  end

  // one transfer; request held until pready is seen at an edge, the slave sets the pace
  // no local limit: only the bench timeout may end a hung access
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] q, output logic err);
    @(posedge sys_clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    do begin
      @(posedge sys_clk);
    end while (pready !== 1'b1);
    q       = prdata;
    err     = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    pwdata  <= ~d;  // released data must not look valid
  endtask : xfer

  // invert the watched bit once per bus cycle, n cycles in a row
  task automatic toggle(input int n);
    logic [31:0] q;
    logic        e;
    repeat (n) begin
      tbit = ~tbit;
      xfer(1'b1, tbw_pkg::ADDR_OUT_IMG, {8'h00, hi, 7'h00, tbit}, q, e);
    end
  endtask : toggle
endmodule : tbw_ctl_model

// >>> sim/tbw_top_tb_top.sv
module tbw_top_tb_top;
  timeunit 1ns;
  timeprecision 1ps;

  localparam int unsigned TK  = 4;  // shortened millisecond tick
  localparam int unsigned PER = 6;  // monitoring period, ticks
  localparam int unsigned MO  = 3;  // min_off_time_setting, ticks

  logic        sys_clk;
  logic        rst_n;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [7:0]  paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic [1:0]  din;
  logic [1:0]  relay;
  logic [1:0]  led_relay;
  logic        led_wd_ok;
  logic [1:0]  led_din;
  logic [31:0] q;
  logic        e;
  int          fail_count = 0;
  int          n_tests = 0;
  int          cyc = 0;
  int          w;

  tbw_top #(.FILT_CYC(3), .TICK_CYC(TK)) u_tbw_top (
    .sys_clk(sys_clk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .din(din), .relay(relay), .led_relay(led_relay), .led_wd_ok(led_wd_ok), .led_din(led_din));

  tbw_ctl_model u_tbw_ctl_model (
    .sys_clk(sys_clk), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));

  // 200 MHz clock
  initial begin
    sys_clk = 1'b0;
    forever #2.5 sys_clk = ~sys_clk;
  end

  task automatic end_of_test;
    $display("checks %0d, mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : end_of_test

  // cut a hang short well beyond the expected few hundred cycles
  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      fail_count++;
      end_of_test();
    end
  end

  task automatic chk(input logic [32:0] got, input logic [32:0] exp, input string m);
    n_tests++;
    if (got !== exp) begin
      fail_count++;
      $display("[FAIL] %0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask : chk

  // one read without a compare, result left in q and e; write data is a don't care
  task automatic peek(input logic [7:0] a);
    u_tbw_ctl_model.xfer(1'b0, a, q, q, e);
  endtask : peek

  // read compares slave error and data together
  task automatic rd(input logic [7:0] a, input logic [32:0] exp, input string m);
    peek(a);
    chk({e, q}, exp, m);
  endtask : rd

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    u_tbw_ctl_model.xfer(1'b1, a, d, q, e);
    chk({32'h0, e}, 33'h0, "write error");
  endtask : wr

  // enable high past the filter, then low; toggling must follow quickly
  task automatic arm;
    din[0] <= 1'b1;
    repeat (12) @(posedge sys_clk);
    din[0] <= 1'b0;
    repeat (7) @(posedge sys_clk);
  endtask : arm

  task automatic wait_relay(input logic [1:0] exp);
    w = 0;
    while (relay !== exp && w < 300) begin
      @(posedge sys_clk);
      w++;
    end
  endtask : wait_relay

  // main sequence
  initial begin
    rst_n = 1'b0;
    din   = 2'b00;
    repeat (12) @(posedge sys_clk);
    rst_n <= 1'b1;
    rd(tbw_pkg::ADDR_PERIOD, {17'h0, tbw_pkg::PERIOD_RST}, "period reset");
    rd(tbw_pkg::ADDR_MIN_OFF, {17'h0, tbw_pkg::MIN_OFF_RST}, "min off reset");
    rd(tbw_pkg::ADDR_IN_IMG, 33'h0_0001_0000, "idle status");
    rd(8'h10, 33'h1_0000_0000, "unmapped read");
    wr(tbw_pkg::ADDR_PERIOD, PER);
    wr(tbw_pkg::ADDR_MIN_OFF, MO);
    u_tbw_ctl_model.hi = 16'h5aa5;
    u_tbw_ctl_model.toggle(2);
    rd(tbw_pkg::ADDR_OUT_IMG, 33'h0_005a_a500, "out image");
    // a steady high enable with good toggling must not arm
    din <= 2'b11;
    u_tbw_ctl_model.toggle(6);
    chk(relay, 2'b00, "armed by level");
    rd(tbw_pkg::ADDR_IN_IMG, 33'h0_0001_0003, "input leds");
    chk(led_din, 2'b11, "led din");
    arm();
    u_tbw_ctl_model.toggle(1);
    chk(relay, 2'b00, "closed on half cycle");
    u_tbw_ctl_model.toggle(1);
    repeat (2) @(posedge sys_clk);
    chk({led_wd_ok, led_relay, relay}, 5'h1f, "start");
    u_tbw_ctl_model.toggle(10);
    chk(relay, 2'b11, "run kept");
    // stuck low: one missed cycle opens both relays
    wait_relay(2'b00);
    chk(w >= (PER - 1) * TK - 2 && w <= (PER + 1) * TK + 2, 1, "stop low time");
    chk({led_wd_ok, led_relay}, 3'h0, "leds off");
    // resumed toggling leaves relays open through and after the off time
    w = cyc;
    do begin
      u_tbw_ctl_model.toggle(1);
      peek(tbw_pkg::ADDR_IN_IMG);
      chk(relay, 2'b00, "reclosed without enable");
    end while (q[23:16] !== 8'h01 && cyc - w < 200);
    chk(cyc - w >= (MO - 1) * TK && cyc - w <= (MO + 2) * TK + 8, 1, "off time");
    // re-arm, then stuck high
    arm();
    u_tbw_ctl_model.toggle(3);
    repeat (2) @(posedge sys_clk);
    chk(relay, 2'b11, "restart");
    wait_relay(2'b00);
    chk(w <= (PER + 1) * TK + 2, 1, "stop high time");
    rd(tbw_pkg::ADDR_IN_IMG, 33'h0_0008_0002, "trip status");
    // armed but never toggled: the period runs out straight into trip
    w = cyc;
    do begin
      peek(tbw_pkg::ADDR_IN_IMG);
    end while (q[23:16] !== 8'h01 && cyc - w < 200);
    arm();
    rd(tbw_pkg::ADDR_IN_IMG, 33'h0_0002_0002, "armed status");
    w = cyc;
    do begin
      peek(tbw_pkg::ADDR_IN_IMG);
    end while (q[23:16] === 8'h02 && cyc - w < 200);
    chk({e, q}, 33'h0_0008_0002, "armed timeout");
    end_of_test();
  end
endmodule : tbw_top_tb_top
